// File: src/evm_vector_map.sv
// Purpose: turn reset, irq and trap events into program counter loads
// Assumes: fetch port answers each read with one memRdValid pulse
// Notes:   boot-mode irq and trap events on the single-serial variant return a branch slot instead of a fetched word
`timescale 1ns/10ps
module evm_vector_map (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // configuration from core
  input  wire evm_pkg::evm_cfg_t cfg,
  input  wire logic [15:0]       vectorTablePointer,
  // event request
  input  wire logic              reqValid,
  input  wire evm_pkg::evm_req_t req,
  output logic                   reqReady,
  // vector word fetch
  output logic                   memRdReq,
  output logic [23:0]            memAddr,
  input  wire logic              memRdValid,
  input  wire logic [23:0]       memRdData,
  // program counter side
  output logic                   vecValid,
  output evm_pkg::evm_vec_t      vec,
  output logic                   reqReject
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01
  } evm_state_t;

  evm_state_t        state_q;
  evm_state_t        state_d;
  logic              resetPend_q;
  logic [23:0]       memAddr_q;
  logic [23:0]       memAddr_d;
  logic              vecValid_q;
  logic              vecValid_d;
  evm_pkg::evm_vec_t vec_q;
  evm_pkg::evm_vec_t vec_d;
  logic              reject_q;
  logic              reject_d;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic [5:0]  slot;
  logic        legal;
  logic        branch;
  logic [23:0] tgtAddr;

  evm_slot_decode u_decode (
    .req                (req),
    .cfg                (cfg),
    .vectorTablePointer (vectorTablePointer),
    .slot               (slot),
    .legal              (legal),
    .branch             (branch),
    .addr               (tgtAddr)
  );

  wire idle      = (state_q == ST_IDLE);
  wire accept    = reqValid && reqReady;
  wire takeBrch  = accept && legal && branch;
  wire takeFetch = accept && legal && !branch;
  wire takeBad   = accept && !legal;
  wire fetchDone = (state_q == ST_FETCH) && memRdValid;

  // a pending reset fetch owns the port before any event
  assign reqReady = idle && !resetPend_q;
  assign memRdReq = (state_q == ST_FETCH);
  assign memAddr  = memAddr_q;
  assign vecValid = vecValid_q;
  assign vec      = vec_q;
  assign reqReject = reject_q;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_d    = state_q;
    memAddr_d  = memAddr_q;
    vecValid_d = 1'b0;
    vec_d      = vec_q;
    reject_d   = takeBad;
    unique case (state_q)
      ST_IDLE:
      begin
        if (resetPend_q)
        begin
          state_d   = ST_FETCH;
          memAddr_d = evm_pkg::RESET_ADDR;
        end
        else if (takeFetch)
        begin
          state_d   = ST_FETCH;
          memAddr_d = tgtAddr;
        end
        else if (takeBrch)
        begin
          // slot holds an instruction; the core executes it in place
          vecValid_d  = 1'b1;
          vec_d.addr  = tgtAddr;
          vec_d.branch = 1'b1;
        end
      end
      ST_FETCH:
      begin
        if (fetchDone)
        begin
          state_d      = ST_IDLE;
          vecValid_d   = 1'b1;
          vec_d.addr   = memRdData;
          vec_d.branch = 1'b0;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q    <= ST_IDLE;
      memAddr_q  <= evm_pkg::RESET_ADDR;
      vecValid_q <= 1'b0;
      vec_q      <= '0;
      reject_q   <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      memAddr_q  <= memAddr_d;
      vecValid_q <= vecValid_d;
      vec_q      <= vec_d;
      reject_q   <= reject_d;
    end
  end

  // cleared once the reset fetch has been launched
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resetPend_q <= 1'b1;
    end
    else if (idle)
    begin
      resetPend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  wire isReloc = (cfg.variant == evm_pkg::VAR_RELOCATABLE);

  sequence s_launch;
    idle && !resetPend_q && takeFetch;
  endsequence

  sequence s_word_back;
    memRdReq ##[0:1000] memRdValid;
  endsequence

  a_reset_fetch_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (idle && resetPend_q) |=> (memRdReq && memAddr == 24'h000000))
    else $error("reset fetch not issued at word zero");

  a_word_to_pc: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_word_back |=> (vecValid && !vec.branch &&
                     vec.addr == $past(memRdData)))
    else $error("fetched vector word not loaded to pc");

  a_fixed_in_range: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_launch and (!isReloc && !branch)) |=> (memAddr <= 24'h00003f))
    else $error("fixed vector outside 00h-3fh");

  a_boot_branch_slot: assert property (
    @(posedge clk) disable iff (!rst_n)
    takeBrch |=> (vecValid && vec.branch && vec.addr >= 24'h809fc1 &&
                  vec.addr <= 24'h809fff && !memRdReq))
    else $error("boot branch slot wrong");

  a_boot_irq_order: assert property (
    @(posedge clk) disable iff (!rst_n)
    (takeBrch && req.kind == evm_pkg::KIND_IRQ) |=>
      (vec.addr == 24'h809fc1 + 24'($past(req.idx))))
    else $error("boot irq slot order wrong");

  a_reloc_aligned: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_launch and (isReloc && req.kind != evm_pkg::KIND_RESET)) |=>
      (memAddr[23:8] == $past(vectorTablePointer) &&
       memAddr[7:0] == {2'h0, $past(slot)}))
    else $error("relocatable vector address wrong");

  a_reloc_reset_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_launch and (isReloc && req.kind == evm_pkg::KIND_RESET)) |=>
      (memAddr == 24'h000000))
    else $error("relocatable reset not at word zero");

  a_trap_reserved: assert property (
    @(posedge clk) disable iff (!rst_n)
    (accept && req.kind == evm_pkg::KIND_TRAP && req.idx > 5'h1b) |=>
      (reqReject && !vecValid && !memRdReq))
    else $error("reserved trap not refused");

  a_serial1_unused: assert property (
    @(posedge clk) disable iff (!rst_n)
    (accept && cfg.variant != evm_pkg::VAR_TWO_SERIAL &&
     req.kind == evm_pkg::KIND_IRQ &&
     (req.idx == 5'h06 || req.idx == 5'h07)) |=> reqReject)
    else $error("second serial slot used");

  a_fixed_slot_map: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_launch and (!isReloc && req.kind == evm_pkg::KIND_IRQ)) |=>
      (memAddr == 24'h000001 + 24'($past(req.idx)) &&
       memAddr <= 24'h00000b))
    else $error("fixed irq slot wrong");

  a_reloc_dma1: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_launch and (isReloc && req.kind == evm_pkg::KIND_IRQ &&
                   req.idx == 5'h0b)) |=> (memAddr[7:0] == 8'h0c))
    else $error("second dma channel slot wrong");

  // power-on fetch ignores the table pointer in microprocessor mode
  a_mp_reset_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (idle && resetPend_q && isReloc && cfg.mpMode) |=>
      (memRdReq && memAddr == 24'h000000))
    else $error("microprocessor reset not fetched at word zero");

endmodule : evm_vector_map

// File: src/evm_pkg.sv
// Purpose: constants, types and carriers for the exception vector map
// Assumes: 24-bit word addresses, single core clock
// Notes:   vector slots are 6-bit offsets; events are reset, irq or trap
package evm_pkg;

  // ----------------------------------------------------------------------
  // widths and addresses
  // ----------------------------------------------------------------------
  localparam int          ADDR_W        = 24;
  localparam int          SLOT_W        = 6;
  localparam int          PTR_W         = 16;
  localparam int          ALIGN_W       = 8;
  localparam logic [23:0] RESET_ADDR    = 24'h000000;
  localparam logic [23:0] FIXED_BASE    = 24'h000000;
  localparam logic [23:0] BOOT_BASE     = 24'h809fc0;
  localparam logic [1:0]  ALIGN_PAD     = 2'h0;

  // ----------------------------------------------------------------------
  // slot offsets
  // ----------------------------------------------------------------------
  localparam logic [5:0]  RESET_SLOT    = 6'h00;
  localparam logic [5:0]  IRQ_SLOT_BASE = 6'h01;
  localparam logic [5:0]  TRAP_BASE     = 6'h20;
  localparam logic [4:0]  TRAP_LAST     = 5'h1b;

  // ----------------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    VAR_TWO_SERIAL    = 2'h0,
    VAR_SINGLE_SERIAL = 2'h1,
    VAR_RELOCATABLE   = 2'h2
  } evm_variant_t;

  typedef enum logic [1:0] {
    KIND_RESET = 2'h0,
    KIND_IRQ   = 2'h1,
    KIND_TRAP  = 2'h2
  } evm_kind_t;

  // irq slot is index plus one; dma_irq doubles as dma channel 0
  typedef enum logic [4:0] {
    EXTERNAL_IRQ_0       = 5'h00,
    EXTERNAL_IRQ_1       = 5'h01,
    EXTERNAL_IRQ_2       = 5'h02,
    EXTERNAL_IRQ_3       = 5'h03,
    SERIAL0_TRANSMIT_IRQ = 5'h04,
    SERIAL0_RECEIVE_IRQ  = 5'h05,
    SERIAL1_TRANSMIT_IRQ = 5'h06,
    SERIAL1_RECEIVE_IRQ  = 5'h07,
    TIMER0_IRQ           = 5'h08,
    TIMER1_IRQ           = 5'h09,
    DMA_IRQ              = 5'h0a,
    DMA_CHANNEL1_IRQ     = 5'h0b
  } evm_irq_t;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    evm_kind_t  kind;
    logic [4:0] idx;
  } evm_req_t;

  typedef struct packed {
    evm_variant_t variant;
    logic         bootMode;
    logic         mpMode;
  } evm_cfg_t;

  typedef struct packed {
    logic [23:0] addr;
    logic        branch;
  } evm_vec_t;

endpackage : evm_pkg

// File: src/evm_slot_decode.sv
// Purpose: map one event to its slot, legality and target address
// Assumes: config and pointer are stable while a request is decoded
// Notes:   purely combinational
`timescale 1ns/10ps
module evm_slot_decode (
  // event and configuration
  input  wire evm_pkg::evm_req_t req,
  input  wire evm_pkg::evm_cfg_t cfg,
  input  wire logic [15:0]       vectorTablePointer,
  // decode results
  output logic [5:0]             slot,
  output logic                   legal,
  output logic                   branch,
  output logic [23:0]            addr
);

  wire         isReset  = (req.kind == evm_pkg::KIND_RESET);
  wire         isIrq    = (req.kind == evm_pkg::KIND_IRQ);
  wire         isTrap   = (req.kind == evm_pkg::KIND_TRAP);
  wire         isReloc  = (cfg.variant == evm_pkg::VAR_RELOCATABLE);
  wire         isSingle = (cfg.variant == evm_pkg::VAR_SINGLE_SERIAL);
  wire [5:0]   irqSlot  = 6'(req.idx) + evm_pkg::IRQ_SLOT_BASE;
  wire [5:0]   trapSlot = evm_pkg::TRAP_BASE | 6'(req.idx);
  wire         ser1Irq  = (req.idx == evm_pkg::SERIAL1_TRANSMIT_IRQ) ||
                          (req.idx == evm_pkg::SERIAL1_RECEIVE_IRQ);
  wire         dma1Irq  = (req.idx == evm_pkg::DMA_CHANNEL1_IRQ);
  wire         irqRange = (req.idx <= evm_pkg::DMA_IRQ) || (dma1Irq && isReloc);
  // second serial port exists only on the two-port variant
  wire         irqLegal = irqRange && !(ser1Irq && !(cfg.variant ==
                          evm_pkg::VAR_TWO_SERIAL));
  wire         trapOk   = req.idx <= evm_pkg::TRAP_LAST;

  assign slot   = isReset ? evm_pkg::RESET_SLOT :
                  isIrq   ? irqSlot : trapSlot;
  assign legal  = isReset || (isIrq && irqLegal) || (isTrap && trapOk);
  assign branch = cfg.bootMode && isSingle && !isReset;

  // reset never goes through the relocatable pointer
  assign addr = isReset ? evm_pkg::RESET_ADDR :
                branch  ? (evm_pkg::BOOT_BASE | 24'(slot)) :
                isReloc ? {vectorTablePointer, evm_pkg::ALIGN_PAD,
                           slot} :
                (evm_pkg::FIXED_BASE | 24'(slot));

endmodule : evm_slot_decode

// File: verif/evm_fetch_model.sv
// Purpose: vector word store that answers the core fetch port
// Assumes: one read outstanding; answer after dly idle cycles
// Notes:   word returned is address xor WORD_XOR
`timescale 1ns/10ps
module evm_fetch_model #(
  parameter logic [23:0] WORD_XOR = 24'h5a3c69
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // fetch port
  input  wire logic        memRdReq,
  input  wire logic [23:0] memAddr,
  output logic             memRdValid,
  output logic [23:0]      memRdData,
  // answer pacing
  input  wire logic [1:0]  dly
);
  logic [1:0] waitCnt_q;

  // data bus scrambles when idle so a stale word is never taken as good
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitCnt_q <= 2'h0;
      memRdValid <= 1'b0;
      memRdData <= 24'h000000;
    end
    else if (memRdReq && !memRdValid && waitCnt_q >= dly)
    begin
      waitCnt_q <= 2'h0;
      memRdValid <= 1'b1;
      memRdData <= memAddr ^ WORD_XOR;
    end
    else
    begin
      waitCnt_q <= (memRdReq && !memRdValid) ? waitCnt_q + 2'h1 : 2'h0;
      memRdValid <= 1'b0;
      memRdData <= ~memRdData;
    end
  end
endmodule : evm_fetch_model

// File: verif/evm_vector_map_tb.sv
// Purpose: self-checking bench for the exception vector map
// Assumes: fetch model answers with a random delay of 0-3 cycles
// Notes:   every variant and boot setting, irq indices 0-15 and all trap indices
`timescale 1ns/10ps
module evm_vector_map_tb;
  localparam logic [23:0] WORD_XOR = 24'h5a3c69;
  logic clk = 1'b0;
  logic rst_n, reqValid, reqReady, memRdReq, memRdValid;
  logic vecValid, reqReject;
  logic [15:0] ptr;
  logic [23:0] memAddr, memRdData;
  logic [1:0] dly;
  evm_pkg::evm_cfg_t cfg;
  evm_pkg::evm_req_t req;
  evm_pkg::evm_vec_t vec;
  int err_count, cmp_count;

  evm_vector_map evm_vector_map_inst (.clk(clk), .rst_n(rst_n),
    .cfg(cfg), .vectorTablePointer(ptr), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .memRdReq(memRdReq), .memAddr(memAddr),
    .memRdValid(memRdValid), .memRdData(memRdData), .vecValid(vecValid),
    .vec(vec), .reqReject(reqReject));

  evm_fetch_model #(.WORD_XOR(WORD_XOR)) evm_fetch_model_inst (.clk(clk),
    .rst_n(rst_n), .memRdReq(memRdReq), .memAddr(memAddr),
    .memRdValid(memRdValid), .memRdData(memRdData), .dly(dly));

  always #10 clk = ~clk;

  // ----------------------------------------------------------------------
  // reference model and checks
  // ----------------------------------------------------------------------
  function automatic void model(input int v, b, k, i, p,
                                output int lg, br, ea);
    int s;
    s = (k == 0) ? 0 : (k == 1) ? i + 1 : 32 + i;
    lg = (k == 0) || (k == 2 && i <= 27) || (k == 1 && i <= 11 &&
         !((i == 6 || i == 7) && v != 0) &&
         !(i == 11 && v != 2));
    br = (v == 1 && b != 0 && k != 0);
    ea = br ? 'h809fc0 + s : (k == 0) ? 0 :
         (v == 2) ? p * 256 + s : s;
  endfunction : model

  task automatic chk(input string nm, input logic [23:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic print_verdict();
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic answer(input int k, input int i);
    int n, lg, br, ea;
    bit f;
    logic [23:0] fa;
    logic rdy;
    f = 0;
    fa = '0;
    rdy = 1'b0;
    model(int'(cfg.variant), int'(cfg.bootMode), k, i, int'(ptr), lg, br, ea);
    for (n = 0; n < 60; n++)
    begin
      @(negedge clk);
      if (memRdReq === 1'b1)
      begin
        f = 1;
        fa = memAddr;
        rdy = reqReady;
      end
      if (vecValid === 1'b1 || reqReject === 1'b1)
        break;
    end
    if (n == 60)
    begin
      err_count++;
      $display("[ERR] answer expected 1 seen 0");
      print_verdict();
    end
    chk("reqReject", 24'(!lg), 24'(reqReject));
    chk("vecValid", 24'(lg), 24'(vecValid));
    chk("fetched", 24'(lg && !br), 24'(f));
    if (f)
    begin
      chk("memAddr", 24'(ea), fa);
      chk("reqReady", 24'h0, 24'(rdy));
    end
    if (lg)
    begin
      chk("branch", 24'(br), 24'(vec.branch));
      chk("vecAddr", br ? 24'(ea) : 24'(ea) ^ WORD_XOR,
          vec.addr);
    end
  endtask : answer

  task automatic send(input int k, input int i);
    int n;
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{evm_pkg::evm_kind_t'(k), 5'(i)};
    dly <= 2'($urandom);
    for (n = 0; n < 60; n++)
    begin
      @(negedge clk);
      if (reqReady === 1'b1)
        break;
    end
    if (n == 60)
    begin
      err_count++;
      $display("[ERR] reqReady expected 1 seen 0");
      print_verdict();
    end
    @(posedge clk);
    reqValid <= 1'b0;
    answer(k, i);
  endtask : send

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    int v, b, k, i;
    void'($urandom(32'h1c96));
    rst_n = 1'b0;
    reqValid = 1'b0;
    req = '0;
    cfg = '0;
    ptr = '0;
    dly = '0;
    err_count = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    for (v = 0; v < 3; v++)
      for (b = 0; b < 2; b++)
      begin
        @(posedge clk);
        rst_n <= 1'b0;
        cfg <= '{evm_pkg::evm_variant_t'(v), b[0], 1'($urandom)};
        ptr <= 16'($urandom);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        answer(0, 0);
        for (k = 0; k < 3; k++)
          for (i = 0; i < 32; i++)
            if (!(k == 0 && i > 0) && !(k == 1 && i > 15))
              send(k, i);
      end
    print_verdict();
  end
endmodule : evm_vector_map_tb
